// [pbd_datapath.sv]
/*
  pbd_datapath: one 8-bit programmable datapath slice with apb register access.
  assumes routing fabric inputs synchronous to core_clk and an apb master.
*/
// Operation
// - one crc or prs step per clock
// - wider crc chains feedback through neighbours
// - crc mode selected per cycle by config
// - programmable top bit position
// - programmable mask on alu result
// - two four-byte queues, independent direction
// - queue status routable to outputs
// - shift, carry, capture, condition chain to neighbours
// - alu shared between two register sets
// - alu and shift results are registered
// - control inputs load and capture queues
// - routed shift in and carry in
// - eight-bit parallel input from routing
// - sixteen signals muxed onto six outputs
// - outputs registered, optionally combinational
// - six bus readable writable working registers
// - accumulators load from alu, bus, queue
// - accumulators and queues zero after wakeup
// - constants keep contents through sleep
// - queue pair any direction combination
// - eight alu functions per cycle
// - eight stored configurations selected per cycle
`timescale 1ns/1ps
module pbd_datapath
  import pbd_pkg::*;
(
  input  wire logic          core_clk,      // 20 mhz
  input  wire logic          arst_n,        // async reset
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic [2:0]    cfg_addr,      // dynamic config select
  input  wire logic          load_zero,     // load from queue_zero
  input  wire logic          load_one,      // load from queue_one
  input  wire logic          capture_zero,  // write queue_zero
  input  wire logic          capture_one,   // write queue_one
  input  wire logic          shift_in,
  input  wire logic          carry_in,
  input  wire logic [7:0]    par_in,
  input  wire logic          wakeup,        // pulse: clear nonretention state
  input  wire pbd_chain_type chain_lo_in,   // from less significant slice
  output pbd_chain_type      chain_hi_out,  // to more significant slice
  output logic [PBD_NOUT-1:0] dp_out
);
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0]  acc_reg [2];        // accumulator_zero / one, bank 0
  logic [7:0]  accb_reg [2];       // second set for time multiplexing
  logic [7:0]  const_reg [2];      // constant_zero / one, retained
  logic [31:0] ctrl_reg;           // static control
  logic [31:0] osel_reg;           // output selects, 4 bits each
  logic [15:0] cfg_mem [8];        // dynamic configuration memory
  logic [7:0]  q_mem [2][PBD_FIFO_DEPTH]; // queue contents
  logic [1:0]  q_rd_reg [2];       // read pointers
  logic [1:0]  q_wr_reg [2];       // write pointers
  logic [2:0]  q_cnt_reg [2];      // fill levels
  logic [PBD_NOUT-1:0] out_reg;    // pipelined outputs
  logic        carry_reg;          // registered carry out, routable as signal three
  logic        cond_reg;           // registered zero detect
  logic [15:0] sig_vec;            // the sixteen internal signals
  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // pready tied high: every access ends at its first access edge
  // offsets compared in full, so an alias reads as unmapped zero, except in the config window, where paddr[1:0] is ignored
  wire wr_acc   = psel && penable && pwrite;
  wire rd_acc   = psel && penable && !pwrite;
  wire sel_cfg  = (paddr[11:5] == PBD_CFG_OFF[11:5]);
  wire [2:0] cfg_idx = paddr[4:2];
  wire [2:0] top_bit  = ctrl_reg[PBD_CTRL_MSB_LSB +: 3];
  wire [7:0] res_mask = ctrl_reg[PBD_CTRL_MASK_LSB +: 8];
  wire [5:0] comb_sel = ctrl_reg[PBD_CTRL_COMB_LSB +: 6];
  pbd_qdir_type q_dir [2];
  assign q_dir[0] = pbd_qdir_type'(ctrl_reg[PBD_CTRL_Q0D_LSB +: 2]);
  assign q_dir[1] = pbd_qdir_type'(ctrl_reg[PBD_CTRL_Q1D_LSB +: 2]);
  assign pready  = 1'b1;                  // always zero wait states
  assign pslverr = 1'b0;
  // ----------------------------------------------------------------
  // dynamic configuration and operand select
  // ----------------------------------------------------------------
  // config word read combinationally, so a new address
  // takes effect at the very next edge
  pbd_cfg_type cfg;
  assign cfg = pbd_cfg_type'(cfg_mem[cfg_addr]);
  wire        bank   = cfg.bank;
  wire [7:0]  acc0_v = bank ? accb_reg[0] : acc_reg[0];
  wire [7:0]  acc1_v = bank ? accb_reg[1] : acc_reg[1];
  wire [7:0]  opa    = cfg.a_par ? par_in : (cfg.dest ? acc1_v : acc0_v);
  wire [7:0]  opb    = cfg.b_const ? const_reg[cfg.dest] : (cfg.dest ? acc0_v : acc1_v);
  wire        cin    = cfg.ci_route ? carry_in : chain_lo_in.carry;
  wire        sin    = cfg.si_route ? shift_in : chain_lo_in.shift;
  // ----------------------------------------------------------------
  // alu, eight functions
  // ----------------------------------------------------------------
  // bit 8 holds carry or borrow out of a full-width operation
  logic [8:0] alu_raw;
  always_comb begin
    case (cfg.func)
      PBD_INC:  alu_raw = {1'b0, opa} + 9'h001;
      PBD_DEC:  alu_raw = {1'b0, opa} - 9'h001;
      PBD_ADD:  alu_raw = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
      PBD_SUB:  alu_raw = {1'b0, opa} - {1'b0, opb};
      PBD_AND:  alu_raw = {1'b0, opa & opb};
      PBD_OR:   alu_raw = {1'b0, opa | opb};
      PBD_XOR:  alu_raw = {1'b0, opa ^ opb};
      default:  alu_raw = {1'b0, opa};
    endcase
  end
  // carry and top bit taken at the programmed msb, not bit 7
  wire       alu_top  = alu_raw[top_bit];
  wire       alu_cout = (top_bit == 3'h7) ? alu_raw[8] : alu_raw[top_bit + 3'h1];
  // ----------------------------------------------------------------
  // shifter with variable top bit
  // ----------------------------------------------------------------
  // bits above a lowered top bit are junk; the mask clears them
  logic [7:0] sh_val;
  logic       sh_out;
  always_comb begin
    sh_val = alu_raw[7:0];
    sh_out = 1'b0;
    case (pbd_shift_type'(cfg.shift_raw))
      PBD_SH_LEFT: begin
        sh_out = alu_top;
        sh_val = {alu_raw[6:0], sin};
      end
      PBD_SH_RIGHT: begin
        sh_out = alu_raw[0];
        sh_val = alu_raw[7:0] >> 1;
        sh_val[top_bit] = sin;
      end
      PBD_SH_SWAP: sh_val = {alu_raw[3:0], alu_raw[7:4]};
      default: sh_val = alu_raw[7:0];
    endcase
  end
  // ----------------------------------------------------------------
  // crc / prs step: shift left, xor polynomial on feedback
  // ----------------------------------------------------------------
  // feedback of a chained slice comes from the less significant slice's feedback chain
  // the destination side's constant serves as the polynomial
  // a lone slice keeps si_route set; chained slices clear it
  wire       crc_fb_local = opa[top_bit] ^ sin;
  wire       crc_fb  = cfg.si_route ? crc_fb_local : chain_lo_in.feedback;
  wire [7:0] crc_val = {opa[6:0], 1'b0} ^ (crc_fb ? const_reg[cfg.dest] : 8'h00);
  wire [7:0] res_pre = cfg.crc ? crc_val : sh_val;
  wire [7:0] result  = res_pre & res_mask;
  // ----------------------------------------------------------------
  // queues
  // ----------------------------------------------------------------
  // push when full and pop when empty are ignored, so software
  // must watch the status bits to avoid losing bytes
  logic [1:0] q_push, q_pop;
  logic [7:0] q_head [2];
  logic [7:0] q_src  [2];
  wire  [1:0] cap_in  = {capture_one, capture_zero};
  wire  [1:0] load_in = {load_one, load_zero};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_q
      wire [11:0] q_off = gi ? PBD_Q1_OFF : PBD_Q0_OFF;
      wire bus_hit = (paddr == q_off);
      wire is_in   = (q_dir[gi] == PBD_Q_IN);
      wire full    = (q_cnt_reg[gi] == 3'(PBD_FIFO_DEPTH));
      wire empty   = (q_cnt_reg[gi] == 3'h0);
      assign q_head[gi] = q_mem[gi][q_rd_reg[gi]];
      assign q_src[gi]  = is_in ? pwdata[7:0] :
                          (q_dir[gi] == PBD_Q_ACC0) ? acc0_v :
                          (q_dir[gi] == PBD_Q_ACC1) ? acc1_v : result;
      // bus writes in input mode, capture in output mode; full drops
      assign q_push[gi] = !full && (is_in ? (wr_acc && bus_hit) : cap_in[gi]);
      assign q_pop[gi]  = !empty && (is_in ? load_in[gi] : (rd_acc && bus_hit));
      // status: bus side not full / not empty, block side empty / full
      assign sig_vec[8 + 2*gi]  = is_in ? !full : !empty;
      assign sig_vec[9 + 2*gi]  = is_in ? empty : full;
      // queue storage and pointers
      // wakeup clears contents too, so a stale byte never reappears
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          q_rd_reg[gi]  <= 2'h0;
          q_wr_reg[gi]  <= 2'h0;
          q_cnt_reg[gi] <= 3'h0;
          for (int k = 0; k < PBD_FIFO_DEPTH; k++) q_mem[gi][k] <= PBD_BYTE_RST;
        end else if (wakeup) begin
          q_rd_reg[gi]  <= 2'h0;
          q_wr_reg[gi]  <= 2'h0;
          q_cnt_reg[gi] <= 3'h0;
          for (int k = 0; k < PBD_FIFO_DEPTH; k++) q_mem[gi][k] <= PBD_BYTE_RST;
        end else begin
          if (q_push[gi]) begin
            q_mem[gi][q_wr_reg[gi]] <= q_src[gi];
            q_wr_reg[gi] <= q_wr_reg[gi] + 2'h1;
          end
          if (q_pop[gi]) q_rd_reg[gi] <= q_rd_reg[gi] + 2'h1;
          q_cnt_reg[gi] <= q_cnt_reg[gi] + {2'h0, q_push[gi]} - {2'h0, q_pop[gi]};
        end
      end
    end
  endgenerate
  // ----------------------------------------------------------------
  // accumulator next values
  // ----------------------------------------------------------------
  // second register set is reachable only through the alu, queue capture and compares,
  // it is not mapped on the bus
  logic [7:0] acc_next [2];
  generate
    for (gi = 0; gi < 2; gi++) begin : g_acc
      wire [11:0] a_off = gi ? PBD_ACC1_OFF : PBD_ACC0_OFF;
      wire alu_wr = cfg.wr_en && (cfg.dest == 1'(gi)) && !bank;
      wire q_ld   = load_in[gi] && (q_dir[gi] == PBD_Q_IN);
      // priority: bus write, then queue load, then alu result
      assign acc_next[gi] = (wr_acc && paddr == a_off) ? pwdata[7:0] :
                            q_ld ? q_head[gi] :
                            alu_wr ? result : acc_reg[gi];
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          acc_reg[gi]  <= PBD_BYTE_RST;
          accb_reg[gi] <= PBD_BYTE_RST;
        end else if (wakeup) begin
          acc_reg[gi]  <= PBD_BYTE_RST;
          accb_reg[gi] <= PBD_BYTE_RST;
        end else begin
          acc_reg[gi] <= acc_next[gi];
          if (cfg.wr_en && bank && cfg.dest == 1'(gi)) accb_reg[gi] <= result;
        end
      end
    end
  endgenerate
  // ----------------------------------------------------------------
  // constants, control and configuration memory
  // ----------------------------------------------------------------
  // constants ignore wakeup so their contents survive sleep
  // control and config words are static and keep as well
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      const_reg[0] <= PBD_BYTE_RST;
      const_reg[1] <= PBD_BYTE_RST;
      ctrl_reg     <= PBD_CTRL_RST;
      osel_reg     <= PBD_OSEL_RST;
      for (int k = 0; k < 8; k++) cfg_mem[k] <= PBD_CFG_RST;
    end else if (wr_acc) begin
      if (paddr == PBD_CONST0_OFF) const_reg[0] <= pwdata[7:0];
      if (paddr == PBD_CONST1_OFF) const_reg[1] <= pwdata[7:0];
      if (paddr == PBD_CTRL_OFF)   ctrl_reg <= pwdata;
      if (paddr == PBD_OSEL_OFF)   osel_reg <= pwdata;
      if (sel_cfg)                 cfg_mem[cfg_idx] <= pwdata[15:0];
    end
  end
  // ----------------------------------------------------------------
  // condition, chain and output muxing
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      carry_reg <= 1'b0;
      cond_reg  <= 1'b0;
    end else begin
      carry_reg <= alu_cout;
      cond_reg  <= (result == 8'h00);
    end
  end
  // chain outputs combinational, so a chained word still
  // completes its step in one cycle
  assign chain_hi_out.shift    = cfg.crc ? opa[top_bit] : sh_out;
  assign chain_hi_out.carry    = alu_cout;
  assign chain_hi_out.capture  = capture_zero | chain_lo_in.capture;
  assign chain_hi_out.cond     = (result == 8'h00) & chain_lo_in.cond;
  assign chain_hi_out.feedback = crc_fb;
  // sixteen internal signals
  assign sig_vec[0]  = cond_reg;                  // zero detect, registered
  assign sig_vec[1]  = result == 8'hFF;           // all ones
  assign sig_vec[2]  = alu_cout;
  assign sig_vec[3]  = carry_reg;
  assign sig_vec[4]  = sh_out;                    // shift out
  assign sig_vec[5]  = crc_fb;                    // crc feedback
  assign sig_vec[6]  = acc0_v == const_reg[0];    // compare zero
  assign sig_vec[7]  = acc1_v == const_reg[1];    // compare one
  assign sig_vec[12] = alu_top;
  assign sig_vec[13] = opa < opb;
  assign sig_vec[14] = result[0];
  assign sig_vec[15] = chain_lo_in.cond;
  // unused selects point at signal zero, the registered zero flag
  logic [PBD_NOUT-1:0] out_mux;
  generate
    for (gi = 0; gi < PBD_NOUT; gi++) begin : g_out
      assign out_mux[gi] = sig_vec[osel_reg[4*gi +: 4]];
      assign dp_out[gi]  = comb_sel[gi] ? out_mux[gi] : out_reg[gi];
    end
  endgenerate
  // one pipeline stage by default on every output
  // the registered path gives routing a full cycle of slack
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) out_reg <= '0;
    else         out_reg <= out_mux;
  end
  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // read data only meaningful during the access phase
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (sel_cfg) rd_mux = {16'h0000, cfg_mem[cfg_idx]};
    else case (paddr)
      PBD_ACC0_OFF:   rd_mux = {24'h000000, acc_reg[0]};
      PBD_ACC1_OFF:   rd_mux = {24'h000000, acc_reg[1]};
      PBD_CONST0_OFF: rd_mux = {24'h000000, const_reg[0]};
      PBD_CONST1_OFF: rd_mux = {24'h000000, const_reg[1]};
      PBD_Q0_OFF:     rd_mux = {24'h000000, q_head[0]};
      PBD_Q1_OFF:     rd_mux = {24'h000000, q_head[1]};
      PBD_CTRL_OFF:   rd_mux = ctrl_reg;
      PBD_OSEL_OFF:   rd_mux = osel_reg;
      PBD_STAT_OFF:   rd_mux = {26'h0000000, q_cnt_reg[1], q_cnt_reg[0]};
      default:        rd_mux = 32'h00000000;
    endcase
  end
  assign prdata = rd_mux;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // every check is off while reset is held
  property p_wake_clear;
    @(posedge core_clk) disable iff (!arst_n)
    wakeup |=> (acc_reg[0] == 8'h00 && acc_reg[1] == 8'h00 && q_cnt_reg[0] == 3'h0);
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("wakeup left state");
  property p_const_keep;
    @(posedge core_clk) disable iff (!arst_n)
    (wakeup && !wr_acc) |=> $stable(const_reg[0]);
  endproperty
  a_const_keep: assert property (p_const_keep) else $error("constant lost");
  property p_mask;
    @(posedge core_clk) disable iff (!arst_n)
    (cfg.wr_en && !bank && !cfg.dest && !load_zero && !wakeup &&
     !(wr_acc && paddr == PBD_ACC0_OFF))
      |=> (acc_reg[0] & ~$past(res_mask)) == 8'h00;
  endproperty
  a_mask: assert property (p_mask) else $error("mask ignored");
  property p_pipe;
    @(posedge core_clk) disable iff (!arst_n)
    !comb_sel[0] ##1 !comb_sel[0] |-> dp_out[0] == $past(out_mux[0]);
  endproperty
  a_pipe: assert property (p_pipe) else $error("output not pipelined");
  property p_q_bound;
    @(posedge core_clk) disable iff (!arst_n)
    q_cnt_reg[0] <= 3'h4 && q_cnt_reg[1] <= 3'h4;
  endproperty
  a_q_bound: assert property (p_q_bound) else $error("queue overflow");
  property p_alu_wb;
    @(posedge core_clk) disable iff (!arst_n)
    (cfg.wr_en && !bank && !cfg.dest && !load_zero && !wakeup &&
     !(wr_acc && paddr == PBD_ACC0_OFF))
      |=> acc_reg[0] == $past(result);
  endproperty
  a_alu_wb: assert property (p_alu_wb) else $error("result not registered");
  property p_cap;
    @(posedge core_clk) disable iff (!arst_n || wakeup)
    (capture_one && q_dir[1] != PBD_Q_IN && q_cnt_reg[1] < 3'h4 && !q_pop[1])
      |=> q_cnt_reg[1] == $past(q_cnt_reg[1]) + 3'h1;
  endproperty
  a_cap: assert property (p_cap) else $error("capture missed");
  property p_stat;
    @(posedge core_clk) disable iff (!arst_n)
    (q_dir[1] == PBD_Q_IN) |-> sig_vec[11] == (q_cnt_reg[1] == 3'h0);
  endproperty
  a_stat: assert property (p_stat) else $error("status wrong");
endmodule : pbd_datapath

// [pbd_pkg.sv]
/*
  pbd_pkg: constants, register map and carrier types for the byte datapath slice.
  assumes a single 20 MHz clock and an APB slave with 32-bit data.
*/
package pbd_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] PBD_ACC0_OFF   = 12'h000; // accumulator_zero
  localparam logic [11:0] PBD_ACC1_OFF   = 12'h004; // accumulator_one
  localparam logic [11:0] PBD_CONST0_OFF = 12'h008; // constant_zero
  localparam logic [11:0] PBD_CONST1_OFF = 12'h00C; // constant_one
  localparam logic [11:0] PBD_Q0_OFF     = 12'h010; // queue_zero
  localparam logic [11:0] PBD_Q1_OFF     = 12'h014; // queue_one
  localparam logic [11:0] PBD_CTRL_OFF   = 12'h018; // static control
  localparam logic [11:0] PBD_OSEL_OFF   = 12'h01C; // output selects
  localparam logic [11:0] PBD_STAT_OFF   = 12'h020; // fifo status
  localparam logic [11:0] PBD_CFG_OFF    = 12'h040; // 8 config words, 4 apart
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int          PBD_CTRL_MSB_LSB  = 0;     // ctrl[2:0] top bit position
  localparam int          PBD_CTRL_MASK_LSB = 8;     // ctrl[15:8] result mask
  localparam int          PBD_CTRL_Q0D_LSB  = 16;    // ctrl[17:16] queue_zero source
  localparam int          PBD_CTRL_Q1D_LSB  = 18;    // ctrl[19:18] queue_one source
  localparam int          PBD_CTRL_COMB_LSB = 24;    // ctrl[29:24] combinational outs
  localparam logic [31:0] PBD_CTRL_RST      = 32'h0000FF07;
  localparam logic [31:0] PBD_OSEL_RST      = 32'h00000000;
  localparam logic [15:0] PBD_CFG_RST       = 16'h0000;
  localparam logic [7:0]  PBD_BYTE_RST      = 8'h00;
  localparam int          PBD_FIFO_DEPTH    = 4;
  localparam int          PBD_NOUT          = 6;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PBD_INC, PBD_DEC, PBD_ADD, PBD_SUB, PBD_AND, PBD_OR, PBD_XOR, PBD_PASS
  } pbd_func_type;
  typedef enum logic [1:0] {PBD_SH_NONE, PBD_SH_LEFT, PBD_SH_RIGHT, PBD_SH_SWAP} pbd_shift_type;
  // queue direction: input from bus, or output sourced from acc0, acc1, alu
  typedef enum logic [1:0] {PBD_Q_IN, PBD_Q_ACC0, PBD_Q_ACC1, PBD_Q_ALU} pbd_qdir_type;
  // one dynamic configuration word
  typedef struct packed {
    logic [2:0]    rsv;      // unused, reads back
    logic          bank;     // time-multiplexed register set
    logic          crc;      // crc / prs step instead of alu
    logic          dest;     // 0 acc_zero, 1 acc_one
    logic          b_const;  // operand b: 0 other accumulator, 1 constant
    logic          a_par;    // operand a: parallel input instead of accumulator
    logic          wr_en;    // write result back
    logic [1:0]    shift_raw;
    pbd_func_type  func;
    logic          ci_route; // use routed carry in
    logic          si_route; // use routed shift in
  } pbd_cfg_type;
  // chain signals to / from a neighbouring slice
  typedef struct packed {
    logic shift;
    logic carry;
    logic capture;
    logic cond;
    logic feedback;
  } pbd_chain_type;
endpackage : pbd_pkg

// [pbd_fabric_model.sv]
/*
  pbd_fabric_model: routing fabric sequencer in front of the datapath slice.
  assumes the bench hands it next-cycle values; it drives them from a register.
*/
`timescale 1ns/1ps
module pbd_fabric_model
  import pbd_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          arst_n,
  input  wire logic [2:0]    nxt_cfg,      // wanted config address
  input  wire logic [3:0]    nxt_ctl,      // load0, load1, capture0, capture1
  input  wire logic          nxt_si,       // wanted shift in
  output logic      [2:0]    cfg_addr,
  output logic               load_zero,
  output logic               load_one,
  output logic               capture_zero,
  output logic               capture_one,
  output logic               shift_in,
  output logic               carry_in,
  output logic      [7:0]    par_in,
  output pbd_chain_type      chain_lo_in
);
  // ----------------------------------------------------------------
  // registered sequencer outputs
  // ----------------------------------------------------------------
  // registered like real pld logic, so every control lasts one whole cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_addr <= 3'h0;
      {load_zero, load_one, capture_zero, capture_one} <= 4'h0;
      shift_in <= 1'b0;
    end else begin
      cfg_addr <= nxt_cfg;
      {load_zero, load_one, capture_zero, capture_one} <= nxt_ctl;
      shift_in <= nxt_si;
    end
  end
  // no neighbour slice here: chain and unused routing held quiet
  assign carry_in    = 1'b0;
  assign par_in      = 8'h00;
  assign chain_lo_in = '0;
endmodule : pbd_fabric_model

// [test_pbd_datapath.sv]
/*
  test_pbd_datapath: apb register tests and datapath step tests for the slice.
  assumes zero-wait apb answers and the fabric model in front of the slice.
*/
`timescale 1ns/1ps
module test_pbd_datapath
  import pbd_pkg::*;
;
  logic core_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, wakeup = 0, nxt_si = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, ld0, ld1, cp0, cp1, si, ci;
  logic [2:0] cfg_addr, nxt_cfg = 3'h0;
  logic [3:0] nxt_ctl = 4'h0;
  logic [7:0] par_in;
  logic [5:0] dp_out;
  pbd_chain_type chi, cho, ch;
  int num_errors = 0, n_checks = 0;
  logic [7:0] exp_tab [8] = '{8'h3D, 8'h3B, 8'h4B, 8'h2D, 8'h0C, 8'h3F, 8'h33, 8'h3C};
  pbd_fabric_model i_pbd_fabric_model (.core_clk(core_clk), .arst_n(arst_n), .nxt_cfg(nxt_cfg),
    .nxt_ctl(nxt_ctl), .nxt_si(nxt_si), .cfg_addr(cfg_addr), .load_zero(ld0), .load_one(ld1),
    .capture_zero(cp0), .capture_one(cp1), .shift_in(si), .carry_in(ci), .par_in(par_in),
    .chain_lo_in(chi));
  pbd_datapath i_pbd_datapath (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cfg_addr(cfg_addr), .load_zero(ld0), .load_one(ld1),
    .capture_zero(cp0), .capture_one(cp1), .shift_in(si), .carry_in(ci), .par_in(par_in),
    .wakeup(wakeup), .chain_lo_in(chi), .chain_hi_out(cho), .dp_out(dp_out));
  // ----------------------------------------------------------------
  // clock, report and bus tasks
  // ----------------------------------------------------------------
  initial forever #25 core_clk = ~core_clk; // 20 mhz
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one apb transfer; waits for pready under a bound, then releases
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin num_errors++; stop_test(); end
    q = prdata; // taken at the completing edge
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask : rd
  // one datapath cycle with the given config address and controls
  task automatic step(input logic [2:0] c, input logic [3:0] k);
    @(posedge core_clk); nxt_cfg <= c; nxt_ctl <= k;
    @(posedge core_clk); nxt_cfg <= 3'h0; nxt_ctl <= 4'h0;
    @(negedge core_clk); ch = cho; // chain outputs while the step is live
    repeat (3) @(posedge core_clk);
  endtask : step
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 6; i++) rd("work reg reset", 12'(4 * i), 32'h0);
    rd("ctrl reset", PBD_CTRL_OFF, PBD_CTRL_RST);
    rd("unmapped", 12'h0F0, 32'h0);
    for (int i = 0; i < 4; i++) apb(1'b1, 12'(4 * i), 32'(8'hA0 + i));
    for (int i = 0; i < 4; i++) rd("work reg", 12'(4 * i), 32'(8'hA0 + i));
    $display("test registers done");
    // every alu function from config word one, operand b from constant_zero
    apb(1'b1, PBD_CONST0_OFF, 32'h0F);
    for (int f = 0; f < 8; f++) begin
      apb(1'b1, PBD_CFG_OFF + 12'h004, 32'(f << 2) | 32'h280);
      apb(1'b1, PBD_ACC0_OFF, 32'h3C);
      step(3'h1, 4'h0);
      rd("alu result", PBD_ACC0_OFF, 32'(exp_tab[f]));
    end
    // pass with a left shift: 0x3C moves up one place, zero shifted in
    apb(1'b1, PBD_CFG_OFF + 12'h004, 32'hBC);
    step(3'h1, 4'h0);
    rd("shift left", PBD_ACC0_OFF, 32'h78);
    // crc step from word two: (0x81 << 1) ^ 0x0F as top bit feeds back
    apb(1'b1, PBD_CFG_OFF + 12'h008, 32'hA81);
    apb(1'b1, PBD_ACC0_OFF, 32'h81);
    step(3'h2, 4'h0);
    rd("crc step", PBD_ACC0_OFF, 32'h0D);
    chk("chain out", {27'h0, ch}, 32'h11);
    // result mask 0x0F clips an increment of 0x0F to zero
    apb(1'b1, PBD_CTRL_OFF, 32'h00000F07);
    apb(1'b1, PBD_CFG_OFF + 12'h004, 32'h280);
    apb(1'b1, PBD_ACC0_OFF, 32'h0F);
    step(3'h1, 4'h0);
    rd("masked inc", PBD_ACC0_OFF, 32'h00);
    // top bit 3: 0x08 feeds back, (0x10 ^ 0x0F) masked to 0x0F
    apb(1'b1, PBD_CTRL_OFF, 32'h00000F03);
    apb(1'b1, PBD_ACC0_OFF, 32'h08);
    step(3'h2, 4'h0);
    rd("crc top bit", PBD_ACC0_OFF, 32'h0F);
    $display("test alu done");
    // queue_zero input, queue_one output from accumulator_one
    apb(1'b1, PBD_CTRL_OFF, 32'h0008FF07);
    for (int i = 1; i < 6; i++) apb(1'b1, PBD_Q0_OFF, 32'(8'h11 * i)); // fifth one dropped
    rd("q0 full count", PBD_STAT_OFF, 32'h04);
    step(3'h0, 4'b1000);
    rd("acc0 from q0", PBD_ACC0_OFF, 32'h11);
    apb(1'b1, PBD_ACC1_OFF, 32'h5A);
    step(3'h0, 4'b0001);
    rd("status", PBD_STAT_OFF, 32'h0B);
    rd("q1 capture", PBD_Q1_OFF, 32'h5A);
    // output 0 queue_zero not full, output 1 its empty flag, rest zero flag
    apb(1'b1, PBD_OSEL_OFF, 32'h98);
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk("dp_out", {26'h0, dp_out}, 32'h1);
    $display("test queues done");
    @(posedge core_clk); wakeup <= 1'b1;
    @(posedge core_clk); wakeup <= 1'b0;
    rd("acc0 wake", PBD_ACC0_OFF, 32'h0);
    rd("status wake", PBD_STAT_OFF, 32'h0);
    rd("const0 kept", PBD_CONST0_OFF, 32'h0F);
    $display("test wakeup done");
    stop_test();
  end
  // whole-run guard against a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    stop_test();
  end
endmodule : test_pbd_datapath
